// ==== tb/pecb_wb_master.sv ====
`timescale 1ns/1ps
module pecb_wb_master (
	input wire logic i_core_clk,
	input wire logic i_wb_ack,
	input wire logic [31:0] i_wb_dat,
	output logic o_wb_cyc,
	output logic o_wb_stb,
	output logic o_wb_we,
	output logic [7:0] o_wb_adr,
	output logic [3:0] o_wb_sel,
	output logic [31:0] o_wb_dat
);
	logic hung;

	initial begin
		o_wb_cyc = 1'b0;
		o_wb_stb = 1'b0;
		o_wb_we = 1'b0;
		o_wb_adr = 8'h00;
		o_wb_sel = 4'h0;
		o_wb_dat = 32'h00000000;
		hung = 1'b0;
	end

	// Call just after a rising edge; returns just after one
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [15:0] wd, output logic [15:0] rd);
		int i;
		o_wb_cyc <= 1'b1;
		o_wb_stb <= 1'b1;
		o_wb_we <= w;
		o_wb_adr <= a;
		o_wb_sel <= 4'h3;
		o_wb_dat <= {16'h0000, wd};
		for (i = 0; i < 20; i++) begin
			@(posedge i_core_clk);
			if (i_wb_ack === 1'b1)
				break;
		end
		if (i == 20)
			hung = 1'b1;
		rd = i_wb_dat[15:0];
		o_wb_cyc <= 1'b0;
		o_wb_stb <= 1'b0;
		@(posedge i_core_clk);
	endtask : xfer
endmodule : pecb_wb_master

// ==== tb/phy_error_counters_bist_control_tb.sv ====
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_errors++; \
	$display("Error %0t: got %h want %h", $time, a, b); end end
module phy_error_counters_bist_control_tb;
	import pecb_pkg::*;
	logic i_core_clk = 1'b0;
	logic i_rstn = 1'b0;
	logic cyc, stb, we, ack, pulse, irq;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] wdat, rdat;
	logic [15:0] d;
	pecb_evt_s evt = '0;
	pecb_ctl_s ctl;
	int n_errors = 0;
	int comparisons = 0;
	int n_pulse = 0;

	always #5 i_core_clk = ~i_core_clk;
	always @(posedge i_core_clk) if (pulse === 1'b1) n_pulse++;
	always @(posedge i_core_clk) if (M.hung === 1'b1) begin
		n_errors++;
		stop_test();
	end

	pecb_top #(.BIST_W(4)) DUT (.i_core_clk(i_core_clk), .i_rstn(i_rstn),
		.i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
		.i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
		.i_evt(evt), .o_ctl(ctl), .o_prbs_max_pulse(pulse), .o_irq(irq));
	pecb_wb_master M (.i_core_clk(i_core_clk), .i_wb_ack(ack),
		.i_wb_dat(rdat), .o_wb_cyc(cyc), .o_wb_stb(stb), .o_wb_we(we),
		.o_wb_adr(adr), .o_wb_sel(sel), .o_wb_dat(wdat));

	task rd(input logic [7:0] a);
		M.xfer(1'b0, a, 16'h0000, d);
	endtask : rd
	task wr(input logic [7:0] a, input logic [15:0] v);
		M.xfer(1'b1, a, v, d);
	endtask : wr
	task tick(input int n);
		repeat (n) @(posedge i_core_clk);
	endtask : tick

	task automatic t_reset;
		logic [7:0] a [6] = '{8'h48, 8'h50, 8'h54, 8'h58, 8'h5C, 8'h40};
		foreach (a[i]) begin
			rd(a[i]);
			`CHK(d, 16'h0000)
		end
		`CHK(ctl, 9'h000)
		$display("reset values done");
	endtask : t_reset

	task t_fc;
		wr(8'h5C, 16'h0200);
		wr(8'h50, 16'hFFFF);
		rd(8'h50);
		`CHK(d, 16'h0000)
		evt.false_carrier <= 1'b1;
		tick(127);
		evt.false_carrier <= 1'b0;
		tick(3);
		`CHK(irq, 1'b0)
		evt.false_carrier <= 1'b1;
		tick(1);
		evt.false_carrier <= 1'b0;
		tick(3);
		`CHK(irq, 1'b1)
		wr(8'h48, 16'h0100);
		`CHK(irq, 1'b1)
		wr(8'h48, 16'h0200);
		`CHK(irq, 1'b0)
		evt.false_carrier <= 1'b1;
		tick(200);
		evt.false_carrier <= 1'b0;
		tick(2);
		rd(8'h50);
		`CHK(d, 16'h00FF)
		rd(8'h50);
		`CHK(d, 16'h0000)
		evt.false_carrier <= 1'b1;
		tick(128);
		evt.false_carrier <= 1'b0;
		tick(3);
		rd(8'h48);
		`CHK(d, 16'h0202)
		`CHK(irq, 1'b0)
		$display("false carrier done");
	endtask : t_fc

	task t_re;
		wr(8'h5C, 16'h0000);
		evt.rx_dv <= 1'b1;
		evt.rx_symbol_err <= 1'b1;
		tick(5);
		evt.mii_loopback <= 1'b1;
		tick(3);
		evt.mii_loopback <= 1'b0;
		evt.rx_dv <= 1'b0;
		tick(3);
		evt.rx_symbol_err <= 1'b0;
		tick(2);
		rd(8'h54);
		`CHK(d, 16'h0005)
		evt.rx_dv <= 1'b1;
		evt.rx_symbol_err <= 1'b1;
		tick(65540);
		evt.rx_symbol_err <= 1'b0;
		tick(3);
		`CHK(irq, 1'b0)
		wr(8'h5C, 16'h0100);
		`CHK(irq, 1'b1)
		rd(8'h54);
		`CHK(d, 16'hFFFF)
		rd(8'h48);
		`CHK(d, 16'h0101)
		`CHK(irq, 1'b0)
		$display("receive errors done");
	endtask : t_re

	task automatic t_bist;
		logic [4:0] c [6] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h03};
		wr(8'h58, 16'h7004);
		`CHK(ctl, {4'hE, 5'h04})
		rd(8'h58);
		`CHK(d, 16'h7004)
		evt.bist_err <= 1'b1;
		tick(15);
		evt.bist_err <= 1'b0;
		tick(3);
		`CHK(n_pulse, 0)
		`CHK(pulse, 1'b0)
		evt.bist_err <= 1'b1;
		tick(1);
		evt.bist_err <= 1'b0;
		tick(3);
		`CHK(n_pulse, 1)
		wr(8'h58, 16'h2000);
		`CHK(ctl, {4'h2, 5'h00})
		evt.bist_err <= 1'b1;
		tick(14);
		evt.bist_err <= 1'b0;
		tick(3);
		`CHK(ctl.prbs_chk_en, 1'b1)
		evt.bist_err <= 1'b1;
		tick(1);
		evt.bist_err <= 1'b0;
		tick(3);
		`CHK(ctl.prbs_chk_en, 1'b0)
		wr(8'h58, 16'h1000);
		`CHK(ctl, {4'h9, 5'h00})
		foreach (c[i]) begin
			wr(8'h58, {11'h000, c[i]});
			`CHK(ctl.loopback, (i < 5) ? c[i] : 5'h00)
		end
		wr(8'h58, 16'h0000);
		evt.chk_locked <= 1'b1;
		evt.chk_sync_lost <= 1'b1;
		tick(1);
		evt.chk_sync_lost <= 1'b0;
		tick(2);
		rd(8'h58);
		`CHK(d, 16'h0C00)
		rd(8'h58);
		`CHK(d, 16'h0800)
		$display("self test done");
	endtask : t_bist

	task stop_test;
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : stop_test

	initial begin
		repeat (16) @(posedge i_core_clk);
		i_rstn <= 1'b1;
		@(posedge i_core_clk);
		t_reset();
		t_fc();
		t_re();
		t_bist();
		stop_test();
	end
endmodule : phy_error_counters_bist_control_tb

// ==== verilog/pecb_pkg.sv ====
package pecb_pkg;
	localparam int unsigned PECB_ADR_W = 8;
	localparam int unsigned PECB_DAT_W = 32;
	localparam int unsigned PECB_REG_W = 16;
	// Register indices; byte address is four times the index
	localparam logic [5:0] PECB_IDX_IRQ_STATUS = 6'h12;
	localparam logic [5:0] PECB_IDX_FC_TALLY = 6'h14;
	localparam logic [5:0] PECB_IDX_RE_TALLY = 6'h15;
	localparam logic [5:0] PECB_IDX_SELF_TEST = 6'h16;
	localparam logic [5:0] PECB_IDX_IRQ_MASK = 6'h17;
	// Counter widths and half-full marks
	localparam int unsigned PECB_FC_W = 8;
	localparam int unsigned PECB_RE_W = 16;
	localparam int unsigned PECB_BIST_W = 16;
	localparam logic [7:0] PECB_FC_HALF = 8'h7F;
	localparam logic [15:0] PECB_RE_HALF = 16'h7FFF;
	// Self-test control fields
	localparam int unsigned PECB_BIT_WRAP = 14;
	localparam int unsigned PECB_BIT_PKT = 13;
	localparam int unsigned PECB_BIT_GEN_EN = 12;
	localparam int unsigned PECB_BIT_LOCK = 11;
	localparam int unsigned PECB_BIT_SYNC = 10;
	localparam int unsigned PECB_LB_LSB = 0;
	localparam int unsigned PECB_LB_W = 5;
	localparam logic [4:0] PECB_LB_PCS_IN = 5'h01;
	localparam logic [4:0] PECB_LB_PCS_OUT = 5'h02;
	localparam logic [4:0] PECB_LB_DIGITAL = 5'h04;
	localparam logic [4:0] PECB_LB_ANALOG = 5'h08;
	localparam logic [4:0] PECB_LB_REVERSE = 5'h10;
	localparam logic [4:0] PECB_LB_RST = 5'h00;
	// Interrupt status and mask layout
	localparam int unsigned PECB_IRQ_FC_BIT = 9;
	localparam int unsigned PECB_IRQ_RE_BIT = 8;
	localparam logic [1:0] PECB_IRQ_MASK_RST = 2'h0;

	typedef struct packed {
		logic false_carrier;
		logic rx_symbol_err;
		logic rx_dv;
		logic mii_loopback;
		logic chk_locked;
		logic chk_sync_lost;
		logic bist_err;
	} pecb_evt_s;

	typedef struct packed {
		logic pkt_gen_en;
		logic prbs_gen_en;
		logic prbs_chk_en;
		logic const_pkt;
		logic [4:0] loopback;
	} pecb_ctl_s;
endpackage : pecb_pkg

// ==== verilog/pecb_sat_counter.sv ====
`timescale 1ns/1ps
module pecb_sat_counter #(
	parameter int unsigned WIDTH = 8
) (
	input wire logic i_core_clk,
	input wire logic i_rstn,
	input wire logic i_inc,
	input wire logic i_clr,
	input wire logic i_wrap,
	output logic [WIDTH-1:0] o_count,
	output logic o_half_evt,
	output logic o_at_max,
	output logic o_wrap_pulse
);
	localparam logic [WIDTH-1:0] CNT_MAX = '1;
	localparam logic [WIDTH-1:0] CNT_HALF = CNT_MAX >> 1;

	generate
		if (WIDTH < 2) begin : g_bad_width
			$error("pecb_sat_counter: WIDTH below 2");
		end
	endgenerate

	logic [WIDTH-1:0] count_reg;
	logic half_reg;
	logic wrap_reg;
	wire at_max = (count_reg == CNT_MAX);
	wire step = i_inc & (~at_max | i_wrap);
	wire [WIDTH-1:0] plus_one = count_reg + 1'b1;
	// An event in the clearing cycle is kept as a count of one
	wire [WIDTH-1:0] count_next = i_clr ? {{(WIDTH-1){1'b0}}, i_inc} :
		(step ? plus_one : count_reg);
	wire half_next = step & ~i_clr & (count_reg == CNT_HALF);
	wire wrap_next = i_inc & i_wrap & at_max & ~i_clr;

	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			count_reg <= '0;
			half_reg <= 1'b0;
			wrap_reg <= 1'b0;
		end else begin
			count_reg <= count_next;
			half_reg <= half_next;
			wrap_reg <= wrap_next;
		end
	end

	assign o_count = count_reg;
	assign o_half_evt = half_reg;
	assign o_at_max = at_max;
	assign o_wrap_pulse = wrap_reg;
endmodule : pecb_sat_counter

// ==== verilog/pecb_sticky.sv ====
`timescale 1ns/1ps
module pecb_sticky #(
	parameter int unsigned WIDTH = 1
) (
	input wire logic i_core_clk,
	input wire logic i_rstn,
	input wire logic [WIDTH-1:0] i_set,
	input wire logic [WIDTH-1:0] i_clr,
	output logic [WIDTH-1:0] o_flag
);
	generate
		if (WIDTH < 1) begin : g_bad_width
			$error("pecb_sticky: WIDTH below 1");
		end
	endgenerate

	logic [WIDTH-1:0] flag_reg;
	// Set beats clear so no event is lost
	wire [WIDTH-1:0] flag_next = i_set | (flag_reg & ~i_clr);

	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			flag_reg <= '0;
		end else begin
			flag_reg <= flag_next;
		end
	end

	assign o_flag = flag_reg;
endmodule : pecb_sticky

// ==== verilog/pecb_top.sv ====
`timescale 1ns/1ps
module pecb_top #(
	parameter int unsigned BIST_W = pecb_pkg::PECB_BIST_W
) (
	input wire logic i_core_clk,
	input wire logic i_rstn,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [pecb_pkg::PECB_ADR_W-1:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [pecb_pkg::PECB_DAT_W-1:0] i_wb_dat,
	output logic [pecb_pkg::PECB_DAT_W-1:0] o_wb_dat,
	output logic o_wb_ack,
	input wire pecb_pkg::pecb_evt_s i_evt,
	output pecb_pkg::pecb_ctl_s o_ctl,
	output logic o_prbs_max_pulse,
	output logic o_irq
);
	import pecb_pkg::*;

	generate
		if (BIST_W < 2 || BIST_W > PECB_REG_W) begin : g_bad_bist
			$error("pecb_top: BIST_W out of range");
		end
	endgenerate

	// Bus slave: request taken in one cycle, ack the next
	logic ack_reg;
	logic [PECB_DAT_W-1:0] rdat_reg;
	logic [5:0] ridx_reg;
	wire take = i_wb_cyc & i_wb_stb & ~ack_reg;
	wire [5:0] idx = i_wb_adr[7:2];
	wire wr = take & i_wb_we;
	wire rd = take & ~i_wb_we;
	wire hit_status = (idx == PECB_IDX_IRQ_STATUS);
	wire hit_fc = (idx == PECB_IDX_FC_TALLY);
	wire hit_re = (idx == PECB_IDX_RE_TALLY);
	wire hit_bist = (idx == PECB_IDX_SELF_TEST);
	wire hit_mask = (idx == PECB_IDX_IRQ_MASK);
	wire wr_lo = wr & i_wb_sel[0];
	wire wr_hi = wr & i_wb_sel[1];

	// Control bits written by software
	logic wrap_reg;
	logic pkt_reg;
	logic gen_en_reg;
	logic [PECB_LB_W-1:0] lb_reg;
	logic [1:0] mask_reg;
	pecb_ctl_s ctl_reg;

	wire wrap_next = (wr_hi & hit_bist) ?
		i_wb_dat[PECB_BIT_WRAP] : wrap_reg;
	wire pkt_next = (wr_hi & hit_bist) ?
		i_wb_dat[PECB_BIT_PKT] : pkt_reg;
	wire gen_en_next = (wr_hi & hit_bist) ?
		i_wb_dat[PECB_BIT_GEN_EN] : gen_en_reg;
	wire [PECB_LB_W-1:0] lb_next = (wr_lo & hit_bist) ?
		i_wb_dat[PECB_LB_LSB +: PECB_LB_W] : lb_reg;
	wire [1:0] mask_next = (wr_hi & hit_mask) ?
		{i_wb_dat[PECB_IRQ_FC_BIT], i_wb_dat[PECB_IRQ_RE_BIT]} : mask_reg;

	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			wrap_reg <= 1'b0;
			pkt_reg <= 1'b0;
			gen_en_reg <= 1'b0;
			lb_reg <= PECB_LB_RST;
			mask_reg <= PECB_IRQ_MASK_RST;
		end else begin
			wrap_reg <= wrap_next;
			pkt_reg <= pkt_next;
			gen_en_reg <= gen_en_next;
			lb_reg <= lb_next;
			mask_reg <= mask_next;
		end
	end

	// Read side effects fire at the take edge, with the data capture
	wire fc_clr = rd & hit_fc;
	wire re_clr = rd & hit_re;
	wire status_rd = rd & hit_status;
	wire bist_rd = rd & hit_bist;

	// False carrier tally
	logic [PECB_FC_W-1:0] fc_cnt;
	logic fc_half;
	pecb_sat_counter #(
		.WIDTH(PECB_FC_W)
	) u_fc_cnt (
		.i_core_clk(i_core_clk),
		.i_rstn(i_rstn),
		.i_inc(i_evt.false_carrier),
		.i_clr(fc_clr),
		.i_wrap(1'b0),
		.o_count(fc_cnt),
		.o_half_evt(fc_half),
		.o_at_max(),
		.o_wrap_pulse()
	);

	// Receive error tally; blind during MII loopback
	wire re_inc = i_evt.rx_symbol_err & i_evt.rx_dv
		& ~i_evt.mii_loopback;
	logic [PECB_RE_W-1:0] re_cnt;
	logic re_half;
	pecb_sat_counter #(
		.WIDTH(PECB_RE_W)
	) u_re_cnt (
		.i_core_clk(i_core_clk),
		.i_rstn(i_rstn),
		.i_inc(re_inc),
		.i_clr(re_clr),
		.i_wrap(1'b0),
		.o_count(re_cnt),
		.o_half_evt(re_half),
		.o_at_max(),
		.o_wrap_pulse()
	);

	// Self-test error counter; restarts whenever the packet bit is clear, holds at max when single mode stalls the checker
	logic [BIST_W-1:0] bist_cnt;
	logic bist_at_max;
	logic bist_wrap;
	wire chk_stalled = ~wrap_reg & bist_at_max;
	wire chk_on = pkt_reg & ~chk_stalled;
	wire bist_inc = i_evt.bist_err & chk_on;
	pecb_sat_counter #(
		.WIDTH(BIST_W)
	) u_bist_cnt (
		.i_core_clk(i_core_clk),
		.i_rstn(i_rstn),
		.i_inc(bist_inc),
		.i_clr(~pkt_reg),
		.i_wrap(wrap_reg),
		.o_count(bist_cnt),
		.o_half_evt(),
		.o_at_max(bist_at_max),
		.o_wrap_pulse(bist_wrap)
	);
	assign o_prbs_max_pulse = bist_wrap;

	// Pending half-full bits: cleared by status read or write-one
	wire [1:0] half_set = {fc_half, re_half};
	wire [1:0] w1c = (wr_hi & hit_status) ?
		{i_wb_dat[PECB_IRQ_FC_BIT], i_wb_dat[PECB_IRQ_RE_BIT]} : 2'h0;
	wire [1:0] half_clr = {2{status_rd}} | w1c;
	logic [1:0] pend;
	pecb_sticky #(
		.WIDTH(2)
	) u_pend (
		.i_core_clk(i_core_clk),
		.i_rstn(i_rstn),
		.i_set(half_set),
		.i_clr(half_clr),
		.o_flag(pend)
	);
	assign o_irq = |(pend & mask_reg);

	// Sync loss latches; a read lets it fall back to the live state
	logic sync_lost;
	pecb_sticky #(
		.WIDTH(1)
	) u_sync (
		.i_core_clk(i_core_clk),
		.i_rstn(i_rstn),
		.i_set(i_evt.chk_sync_lost),
		.i_clr(bist_rd),
		.o_flag(sync_lost)
	);

	// Illegal loopback codes select no loopback
	wire lb_legal = (lb_reg == PECB_LB_PCS_IN) ||
		(lb_reg == PECB_LB_PCS_OUT) || (lb_reg == PECB_LB_DIGITAL) ||
		(lb_reg == PECB_LB_ANALOG) || (lb_reg == PECB_LB_REVERSE);

	pecb_ctl_s ctl_next;
	always_comb begin
		ctl_next = '0;
		ctl_next.pkt_gen_en = gen_en_reg;
		ctl_next.prbs_gen_en = gen_en_reg & pkt_reg;
		ctl_next.prbs_chk_en = chk_on;
		ctl_next.const_pkt = gen_en_reg & ~pkt_reg;
		ctl_next.loopback = lb_legal ? lb_reg : PECB_LB_RST;
	end

	// Read data; reserved bits are never stored, so they read zero
	logic [PECB_REG_W-1:0] st_val;
	logic [PECB_REG_W-1:0] bist_val;
	always_comb begin
		st_val = '0;
		st_val[PECB_IRQ_FC_BIT] = pend[1];
		st_val[PECB_IRQ_RE_BIT] = pend[0];
		st_val[PECB_IRQ_FC_BIT-8] = mask_reg[1];
		st_val[PECB_IRQ_RE_BIT-8] = mask_reg[0];
		bist_val = '0;
		bist_val[PECB_BIT_WRAP] = wrap_reg;
		bist_val[PECB_BIT_PKT] = pkt_reg;
		bist_val[PECB_BIT_GEN_EN] = gen_en_reg;
		bist_val[PECB_BIT_LOCK] = i_evt.chk_locked;
		bist_val[PECB_BIT_SYNC] = sync_lost;
		bist_val[PECB_LB_LSB +: PECB_LB_W] = lb_reg;
	end

	wire [PECB_REG_W-1:0] mask_val = {6'h00,
		mask_reg[1], mask_reg[0], 8'h00};
	wire [PECB_REG_W-1:0] fc_val = {8'h00, fc_cnt};
	wire [PECB_REG_W-1:0] rd_mux =
		hit_fc ? fc_val :
		hit_re ? re_cnt :
		hit_bist ? bist_val :
		hit_status ? st_val :
		hit_mask ? mask_val : 16'h0000;
	wire [PECB_DAT_W-1:0] rdat_next = rd ? {16'h0000, rd_mux} : rdat_reg;

	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			ack_reg <= 1'b0;
			rdat_reg <= '0;
			ridx_reg <= '0;
			ctl_reg <= '0;
		end else begin
			ack_reg <= take;
			rdat_reg <= rdat_next;
			ridx_reg <= take ? idx : ridx_reg;
			ctl_reg <= ctl_next;
		end
	end

	assign o_wb_ack = ack_reg;
	assign o_wb_dat = rdat_reg;
	assign o_ctl = ctl_reg;

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rstn);

	a_fc_counts_up:
	assert property (i_evt.false_carrier && !fc_clr && fc_cnt != 8'hFF
		|=> fc_cnt == $past(fc_cnt) + 8'h01)
	else $error("false carrier tally did not step");

	a_fc_saturates:
	assert property (fc_cnt == 8'hFF && !fc_clr |=> fc_cnt == 8'hFF)
	else $error("false carrier tally left FFh");

	a_fc_half_pends:
	assert property (i_evt.false_carrier && fc_cnt == 8'h7F && !fc_clr
		|-> ##2 pend[1])
	else $error("false carrier half-full not pending");

	a_read_clears:
	assert property (fc_clr && !i_evt.false_carrier
		|=> fc_cnt == 8'h00 ##1 o_wb_dat[7:0] == $past(fc_cnt, 2))
	else $error("tally read did not return then clear");

	a_reserved_zero:
	assert property (o_wb_ack && ridx_reg == PECB_IDX_FC_TALLY
		|-> o_wb_dat[31:8] == 24'h000000)
	else $error("reserved tally bits not zero");

	a_re_counts_dv:
	assert property (i_evt.rx_symbol_err && !i_evt.rx_dv && !re_clr
		|=> re_cnt == $past(re_cnt))
	else $error("receive error counted without data valid");

	a_re_loopback:
	assert property (i_evt.mii_loopback && !re_clr
		|=> $stable(re_cnt))
	else $error("receive error counted in MII loopback");

	a_re_saturates:
	assert property (re_cnt == 16'hFFFF && !re_clr |=> re_cnt == 16'hFFFF)
	else $error("receive error tally left FFFFh");

	a_re_half_pends:
	assert property (re_inc && re_cnt == 16'h7FFF && !re_clr
		|-> ##2 pend[0])
	else $error("receive error half-full not pending");

	a_bist_wraps:
	assert property (wrap_reg && bist_inc && bist_at_max && pkt_reg
		|=> bist_cnt == '0 && o_prbs_max_pulse)
	else $error("continuous self-test count did not wrap");

	a_single_stops:
	assert property (!wrap_reg && bist_at_max && pkt_reg
		|=> !o_ctl.prbs_chk_en && bist_at_max)
	else $error("single mode checker kept counting");

	a_pkt_off_const:
	assert property (!pkt_reg && gen_en_reg
		|=> o_ctl.const_pkt && !o_ctl.prbs_chk_en && !o_ctl.prbs_gen_en)
	else $error("constant packet mode wrong");

	a_sync_latches:
	assert property (i_evt.chk_sync_lost ##1 (!bist_rd) [*3]
		|-> sync_lost)
	else $error("sync loss flag fell before read");

	a_loopback_onehot:
	assert property ($onehot0(o_ctl.loopback))
	else $error("loopback select not one-hot");

	a_prbs_pkt_on:
	assert property (pkt_reg && !bist_at_max
		|=> o_ctl.prbs_chk_en && o_ctl.prbs_gen_en == $past(gen_en_reg))
	else $error("packet bit set but PRBS path off");

	a_gen_en_follows:
	assert property (wr_hi && hit_bist
		|=> ##1 o_ctl.pkt_gen_en == $past(i_wb_dat[PECB_BIT_GEN_EN], 2))
	else $error("generator enable did not follow write");

	a_lock_live:
	assert property (o_wb_ack && !$past(i_wb_we) && ridx_reg == PECB_IDX_SELF_TEST
		|-> o_wb_dat[PECB_BIT_LOCK] == $past(i_evt.chk_locked))
	else $error("lock flag did not show live state");

	a_sync_sets:
	assert property (i_evt.chk_sync_lost |=> sync_lost)
	else $error("sync loss flag did not latch");

	a_half_pend_sets:
	assert property (fc_half |=> pend[1])
	else $error("half-full event did not pend");
endmodule : pecb_top
